// [pkg/pch_regs.vh]
// register map, message fields and codes of the port configuration handler
`ifndef PCH_REGS_VH
`define PCH_REGS_VH
// ====================================================================
// register byte offsets
`define PCH_REQ0 8'h00
`define PCH_REQ1 8'h04
`define PCH_REQ2 8'h08
`define PCH_REQ3 8'h0C
`define PCH_REQ4 8'h10
`define PCH_CTRL 8'h14
`define PCH_CFG 8'h18
`define PCH_STAT 8'h1C
`define PCH_RADDR 8'h20
`define PCH_ALERT 8'h24
`define PCH_ATAG 8'h28
`define PCH_AADDR 8'h2C
`define PCH_PORT0 8'h30
`define PCH_PORT1 8'h34
// ====================================================================
// control strobe bits
`define PCH_CTRL_GO 0
`define PCH_CTRL_CLR 1
`define PCH_CTRL_AACK 2
`define PCH_CTRL_RACK 3
// ====================================================================
// message codes and values
`define PCH_CODE_CFG 8'h02
`define PCH_RC_OK 8'h00
`define PCH_RC_INVALID 8'hFF
`define PCH_MODE_KEEP 2'h0
`define PCH_MODE_WRAP 2'h1
`define PCH_MODE_NORMAL 2'h2
`define PCH_MODE_PRIV 2'h3
`define PCH_MODE_RESET 2'h3
`define PCH_NODE_DUAL 2'h0
`define PCH_NODE_SINGLE 2'h1
`define PCH_NODE_SWITCH 2'h2
`define PCH_AL_THR_TYPE 8'h1A
`define PCH_AL_THR_SUB 8'h00
`define PCH_AL_SPD_TYPE 8'h06
`define PCH_AL_SPD_SUB 8'h05
`define PCH_SPEED_SLOW 8'h00
`define PCH_WIN_DEFAULT_MAX 16'h0001
`define PCH_CNT_MAX 8'hFF
`endif

// [src/pch_port_cfg.v]
// port configuration request handler with an AHB-Lite register slave
// How it works
// - code 02h requests are configuration; every request gets a response
// - keep the request tag per port and use it in later alerts
// - return path becomes address of response and later alerts
// - max quota below base quota: discard, answer invalid field
// - user char enable gates sending and forwarding of user characters
// - dual node: reflect sets mirror; clear only if both ports operational
// - single port and switch nodes ignore the reflect bit
// - mode field: keep, wrap, normal, privileged
// - keep mode with alerts pending: send alerts before the response
// - wrap accepted only via another port, else invalid and unchanged
// - entering wrap makes the port not operational
// - wrap port asked privileged via other port leaves wrap, starts link
// - wrap port asked normal via other port stays wrap, invalid field
// - one alarm alert when recovery count equals nonzero threshold
// - clear count request zeroes recovery count and rearms the alarm
// - speed bits: none keeps, slow only, fast only, both allowed
// - a single allowed rate makes the port act single speed
// - window 0 or 1 is default link, larger is extended, size+1 buffers
// - newest accepted request overwrites stored parameters; keep codes leave speed bits and mode as they were
// - dual rate port running slow raises alert after the response
// - slow speed alert is type 06h subtype 05h, speed as info
//
// The AHB-Lite slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "pch_regs.vh"
module pch_port_cfg (
   input wire clock_in,
   input wire rst_b_in,
   input wire hsel_in,
   input wire [31:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output wire [31:0] hrdata_out,
   output wire hreadyout_out,
   output wire hresp_out,
   input wire [1:0] link_recovery_event_in,
   input wire [1:0] link_up_in,
   input wire [1:0] slow_speed_in,
   output wire [3:0] port_mode_out,
   output wire [1:0] port_operational_out,
   output wire [1:0] user_char_enable_out,
   output wire [1:0] allow_fast_rate_out,
   output wire [1:0] allow_slow_rate_out,
   output wire [1:0] single_speed_out,
   output wire [1:0] extended_window_out,
   output wire [33:0] window_buffers_out,
   output wire [15:0] quota_out,
   output wire [1:0] begin_comm_out,
   output wire mirror_flag_out
);
   localparam ST_IDLE = 2'h0;
   localparam ST_EXEC = 2'h1;
   localparam ST_HOLD = 2'h2;
   integer i, j;
   // ==================================================================
   // bus slave
   reg aw_q;
   reg [7:0] ad_q;
   reg [31:0] hrdata_q;
   reg [31:0] rd_d;
   reg [31:0] req0_q, req1_q, req2_q, req3_q, req4_q;
   reg [1:0] node_type_q;
   reg dual_rate_q;
   wire addr_ok = hsel_in & htrans_in[1] & hready_in;
   wire wr_ctrl = aw_q & (ad_q == `PCH_CTRL);
   wire go_s = wr_ctrl & hwdata_in[`PCH_CTRL_GO];
   wire clr_s = wr_ctrl & hwdata_in[`PCH_CTRL_CLR];
   wire aack_s = wr_ctrl & hwdata_in[`PCH_CTRL_AACK];
   wire rack_s = wr_ctrl & hwdata_in[`PCH_CTRL_RACK];
   wire [7:0] clr_port = hwdata_in[15:8];
   wire [7:0] via_port = hwdata_in[23:16];
   // zero wait states, always OKAY; unmapped reads give zero
   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign hrdata_out = hrdata_q;
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         aw_q <= 1'b0;
         ad_q <= 8'h00;
         hrdata_q <= 32'h0000_0000;
      end else begin
         aw_q <= addr_ok & hwrite_in;
         if (addr_ok) begin
            ad_q <= haddr_in[7:0];
         end
         if (addr_ok & ~hwrite_in) begin
            hrdata_q <= rd_d;
         end
      end
   end
   // request and configuration words written in the data phase
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         req0_q <= 32'h0000_0000;
         req1_q <= 32'h0000_0000;
         req2_q <= 32'h0000_0000;
         req3_q <= 32'h0000_0000;
         req4_q <= 32'h0000_0000;
         node_type_q <= `PCH_NODE_DUAL;
         dual_rate_q <= 1'b1;
      end else if (aw_q) begin
         case (ad_q)
            `PCH_REQ0: req0_q <= hwdata_in;
            `PCH_REQ1: req1_q <= hwdata_in;
            `PCH_REQ2: req2_q <= hwdata_in;
            `PCH_REQ3: req3_q <= hwdata_in;
            `PCH_REQ4: req4_q <= hwdata_in;
            `PCH_CFG: begin
               node_type_q <= hwdata_in[1:0];
               dual_rate_q <= hwdata_in[2];
            end
            default: ;
         endcase
      end
   end
   // ==================================================================
   // request fields
   wire [7:0] q_code = req0_q[31:24];
   wire [7:0] q_port = req0_q[23:16];
   wire [15:0] q_tag = req0_q[15:0];
   wire [7:0] q_aq = req2_q[23:16];
   wire [7:0] q_bq = req2_q[15:8];
   wire q_uce = req2_q[7];
   wire q_refl = req2_q[6];
   wire [1:0] q_mode = req2_q[5:4];
   wire [7:0] q_thr = req3_q[23:16];
   wire [1:0] q_neg = req3_q[1:0];
   wire [15:0] q_win = req4_q[31:16];
   wire pi = q_port[0];
   // ==================================================================
   // pin synchronisers; edge detectors compare the second and third stages
   reg [1:0] ev1_q, ev2_q, ev3_q, up1_q, up2_q, up3_q, sl1_q, sl2_q;
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         ev1_q <= 2'h0;
         ev2_q <= 2'h0;
         ev3_q <= 2'h0;
         up1_q <= 2'h0;
         up2_q <= 2'h0;
         up3_q <= 2'h0;
         sl1_q <= 2'h0;
         sl2_q <= 2'h0;
      end else begin
         ev1_q <= link_recovery_event_in;
         ev2_q <= ev1_q;
         ev3_q <= ev2_q;
         up1_q <= link_up_in;
         up2_q <= up1_q;
         up3_q <= up2_q;
         sl1_q <= slow_speed_in;
         sl2_q <= sl1_q;
      end
   end
   wire [1:0] ev_rise = ev2_q & ~ev3_q;
   wire [1:0] up_rise = up2_q & ~up3_q;
   // ==================================================================
   // per port state and handler machine
   reg [1:0] st_q;
   reg [7:0] via_q;
   reg [1:0] mode_q [0:1];
   reg [15:0] tag_q [0:1];
   reg [31:0] path_q [0:1];
   reg [7:0] aq_q [0:1];
   reg [7:0] bq_q [0:1];
   reg [7:0] thr_q [0:1];
   reg [7:0] cnt_q [0:1];
   reg [15:0] win_q [0:1];
   reg [1:0] oper_q, uce_q, fast_q, slow_q, bc_q;
   reg mirror_q, resp_v_q, resp_fire_q;
   reg [7:0] resp_rc_q;
   reg [15:0] resp_tag_q;
   reg [31:0] resp_addr_q;
   reg [1:0] alarm_q, spd_q;
   wire [1:0] pend = alarm_q | spd_q;
   // reject checks; reserved fields are never looked at
   wire bad = (q_code != `PCH_CODE_CFG) | (q_port > 8'h01)
      | (q_bq < q_aq)
      | ((q_mode == `PCH_MODE_WRAP) & (via_q == q_port))
      | ((q_mode == `PCH_MODE_NORMAL)
         & (mode_q[pi] == `PCH_MODE_WRAP));
   wire hold = ~bad & (q_mode == `PCH_MODE_KEEP) & pend[pi];
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         st_q <= ST_IDLE;
         via_q <= 8'h00;
         for (j = 0; j < 2; j = j + 1) begin
            mode_q[j] <= `PCH_MODE_RESET;
            tag_q[j] <= 16'h0000;
            path_q[j] <= 32'h0000_0000;
            aq_q[j] <= 8'h01;
            bq_q[j] <= 8'h01;
            thr_q[j] <= 8'h00;
            win_q[j] <= 16'h0000;
         end
         oper_q <= 2'h0;
         uce_q <= 2'h0;
         fast_q <= 2'h3;
         slow_q <= 2'h3;
         bc_q <= 2'h0;
         mirror_q <= 1'b0;
         resp_v_q <= 1'b0;
         resp_fire_q <= 1'b0;
         resp_rc_q <= `PCH_RC_OK;
         resp_tag_q <= 16'h0000;
         resp_addr_q <= 32'h0000_0000;
      end else begin
         bc_q <= 2'h0;
         resp_fire_q <= 1'b0;
         oper_q <= oper_q | up_rise;
         if (rack_s) begin
            resp_v_q <= 1'b0;
         end
         case (st_q)
            ST_IDLE: begin
               if (go_s) begin
                  via_q <= via_port;
                  st_q <= ST_EXEC;
               end
            end
            ST_EXEC, ST_HOLD: begin
               if (hold) begin
                  st_q <= ST_HOLD;
               end else begin
                  st_q <= ST_IDLE;
                  // every request answered, tag echoed
                  resp_v_q <= 1'b1;
                  resp_fire_q <= ~bad;
                  resp_tag_q <= q_tag;
                  resp_addr_q <= req1_q;
                  resp_rc_q <= bad ? `PCH_RC_INVALID : `PCH_RC_OK;
                  if (!bad) begin
                     // newest request replaces the old set; keep codes leave speed bits and mode
                     tag_q[pi] <= q_tag;
                     path_q[pi] <= req1_q;
                     aq_q[pi] <= q_aq;
                     bq_q[pi] <= q_bq;
                     thr_q[pi] <= q_thr;
                     win_q[pi] <= q_win;
                     uce_q[pi] <= q_uce;
                     if (q_neg != 2'h0) begin
                        fast_q[pi] <= q_neg[1];
                        slow_q[pi] <= q_neg[0];
                     end
                     if (node_type_q == `PCH_NODE_DUAL) begin
                        if (q_refl) begin
                           mirror_q <= 1'b1;
                        end else if (&oper_q) begin
                           mirror_q <= 1'b0;
                        end
                     end
                     case (q_mode)
                        `PCH_MODE_WRAP: begin
                           mode_q[pi] <= `PCH_MODE_WRAP;
                           oper_q[pi] <= 1'b0;
                        end
                        `PCH_MODE_NORMAL: mode_q[pi] <= `PCH_MODE_NORMAL;
                        `PCH_MODE_PRIV: begin
                           mode_q[pi] <= `PCH_MODE_PRIV;
                           if (mode_q[pi] == `PCH_MODE_WRAP
                              && via_q != q_port) begin
                              bc_q[pi] <= 1'b1;
                           end
                        end
                        default: ;
                     endcase
                  end
               end
            end
            default: st_q <= ST_IDLE;
         endcase
      end
   end
   // ==================================================================
   // recovery counters and alert flags; a flag set beats a same cycle acknowledge, a count clear beats an event
   wire [1:0] apick;
   assign apick[0] = pend[0];
   assign apick[1] = ~pend[0] & pend[1];
   wire a_thr = alarm_q[0] | (~pend[0] & alarm_q[1]);
   wire a_port = ~pend[0];
   always @(posedge clock_in) begin
      if (!rst_b_in) begin
         alarm_q <= 2'h0;
         spd_q <= 2'h0;
         for (i = 0; i < 2; i = i + 1) begin
            cnt_q[i] <= 8'h00;
         end
      end else begin
         for (i = 0; i < 2; i = i + 1) begin
            if (clr_s && clr_port == i) begin
               cnt_q[i] <= 8'h00;
            end else if (ev_rise[i] && cnt_q[i] != `PCH_CNT_MAX) begin
               cnt_q[i] <= cnt_q[i] + 8'h01;
            end
            // only the step that lands on the threshold fires
            if (ev_rise[i] && !(clr_s && clr_port == i)
               && thr_q[i] != 8'h00 && cnt_q[i] + 8'h01 == thr_q[i]
               && cnt_q[i] != `PCH_CNT_MAX) begin
               alarm_q[i] <= 1'b1;
            end else if (aack_s && apick[i] && a_thr) begin
               alarm_q[i] <= 1'b0;
            end
            // raised after the response of an accepted request
            if (resp_fire_q && pi == i && dual_rate_q && sl2_q[i]) begin
               spd_q[i] <= 1'b1;
            end else if (aack_s && apick[i] && !a_thr) begin
               spd_q[i] <= 1'b0;
            end
         end
      end
   end
   // ==================================================================
   // read mux; alert shows tag and path of the port it belongs to
   always @* begin
      rd_d = 32'h0000_0000;
      case (haddr_in[7:0])
         `PCH_REQ0: rd_d = req0_q;
         `PCH_REQ1: rd_d = req1_q;
         `PCH_REQ2: rd_d = req2_q;
         `PCH_REQ3: rd_d = req3_q;
         `PCH_REQ4: rd_d = req4_q;
         `PCH_CFG: rd_d = {29'h0, dual_rate_q, node_type_q};
         `PCH_STAT: rd_d = {resp_tag_q, resp_rc_q, 5'h00, mirror_q,
            (st_q != ST_IDLE), resp_v_q};
         `PCH_RADDR: rd_d = resp_addr_q;
         `PCH_ALERT: begin
            if (a_thr) begin
               rd_d = {8'h00, `PCH_AL_THR_TYPE, `PCH_AL_THR_SUB,
                  6'h00, a_port, |pend};
            end else if (|pend) begin
               rd_d = {`PCH_SPEED_SLOW, `PCH_AL_SPD_TYPE,
                  `PCH_AL_SPD_SUB, 6'h00, a_port, |pend};
            end
         end
         `PCH_ATAG: rd_d = {16'h0000, tag_q[a_port]};
         `PCH_AADDR: rd_d = path_q[a_port];
         `PCH_PORT0: rd_d = {16'h0000, cnt_q[0], 2'h0, fast_q[0],
            slow_q[0], uce_q[0], oper_q[0], mode_q[0]};
         `PCH_PORT1: rd_d = {16'h0000, cnt_q[1], 2'h0, fast_q[1],
            slow_q[1], uce_q[1], oper_q[1], mode_q[1]};
         default: rd_d = 32'h0000_0000;
      endcase
   end
   // ==================================================================
   // port controls toward the link logic
   assign port_mode_out = {mode_q[1], mode_q[0]};
   assign port_operational_out = oper_q;
   assign user_char_enable_out = uce_q;
   assign allow_fast_rate_out = fast_q;
   assign allow_slow_rate_out = slow_q;
   assign single_speed_out = fast_q ^ slow_q;
   assign extended_window_out = {win_q[1] > `PCH_WIN_DEFAULT_MAX,
      win_q[0] > `PCH_WIN_DEFAULT_MAX};
   // buffer count is one more than the window field
   assign window_buffers_out = {{1'b0, win_q[1]} + 17'h00001,
      {1'b0, win_q[0]} + 17'h00001};
   // quotas of the port named in the current request word, base then maximum
   assign quota_out = {aq_q[pi], bq_q[pi]};
   assign begin_comm_out = bc_q;
   assign mirror_flag_out = mirror_q;
endmodule // pch_port_cfg

// [test/pch_port_cfg_chk.sv]
// checker of the port configuration handler output relations
`timescale 1ns/1ps
module pch_port_cfg_chk (
   input wire clock_in,
   input wire rst_b_in,
   input wire [3:0] port_mode_out,
   input wire [1:0] port_operational_out,
   input wire [1:0] allow_fast_rate_out,
   input wire [1:0] allow_slow_rate_out,
   input wire [1:0] single_speed_out,
   input wire [1:0] extended_window_out,
   input wire [33:0] window_buffers_out,
   input wire [1:0] begin_comm_out
);
   // ==================================================================
   // output relations, all in the one clock domain
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   AST_SINGLE_SPEED: assert property (
      single_speed_out == (allow_fast_rate_out ^ allow_slow_rate_out))
      else $error("single speed flag wrong");
   AST_SOME_RATE: assert property (
      (allow_fast_rate_out | allow_slow_rate_out) == 2'h3)
      else $error("a port allows no rate");
   AST_EXT_WIN0: assert property (
      extended_window_out[0] == (window_buffers_out[16:0] > 17'h2))
      else $error("port 0 window kind wrong");
   AST_EXT_WIN1: assert property (
      extended_window_out[1] == (window_buffers_out[33:17] > 17'h2))
      else $error("port 1 window kind wrong");
   AST_WRAP_NOT_OPER: assert property (
      port_mode_out[3:2] == 2'h1 && $past(port_mode_out[3:2]) != 2'h1
      |-> !port_operational_out[1])
      else $error("wrap port still operational");
   AST_WRAP_NO_NORMAL: assert property (
      $past(port_mode_out[3:2]) == 2'h1 |-> port_mode_out[3:2] != 2'h2)
      else $error("wrap port went straight to normal");
   // the pulse and the mode change come from the same clock edge
   AST_BEGIN_FROM_WRAP: assert property (
      $rose(begin_comm_out[1]) |-> port_mode_out[3:2] == 2'h3 &&
      ($past(port_mode_out[3:2]) == 2'h1 ||
      $past(port_mode_out[3:2], 2) == 2'h1))
      else $error("link start without wrap exit");
   AST_BEGIN_PULSE: assert property (
      begin_comm_out[1] |=> !begin_comm_out[1])
      else $error("link start pulse too long");
   AST_MODE_STATE: assert property (
      port_mode_out[1:0] != 2'h0 && port_mode_out[3:2] != 2'h0)
      else $error("keep code held as a mode");
endmodule // pch_port_cfg_chk
bind pch_port_cfg pch_port_cfg_chk u_chk (
   .clock_in(clock_in),
   .rst_b_in(rst_b_in),
   .port_mode_out(port_mode_out),
   .port_operational_out(port_operational_out),
   .allow_fast_rate_out(allow_fast_rate_out),
   .allow_slow_rate_out(allow_slow_rate_out),
   .single_speed_out(single_speed_out),
   .extended_window_out(extended_window_out),
   .window_buffers_out(window_buffers_out),
   .begin_comm_out(begin_comm_out)
);

// [test/pch_link_model.sv]
// behavioural model of the link side feeding the handler
`timescale 1ns/1ps
module pch_link_model (
   input wire clock_in,
   output logic [1:0] link_recovery_event_out = 2'h0,
   output logic [1:0] link_up_out = 2'h0,
   output logic [1:0] slow_speed_out = 2'h0
);
   // ==================================================================
   // link events, each held long enough for the 2-ff synchroniser
   task automatic recover(input int p);
      link_recovery_event_out[p] <= 1'b1;
      repeat (3) @(posedge clock_in);
      link_recovery_event_out[p] <= 1'b0;
      repeat (4) @(posedge clock_in);
   endtask
   // drop first so that a fresh rising edge is always seen
   task automatic come_up(input int p);
      link_up_out[p] <= 1'b0;
      repeat (3) @(posedge clock_in);
      link_up_out[p] <= 1'b1;
      repeat (4) @(posedge clock_in);
   endtask
   task automatic set_slow(input int p, input logic s);
      slow_speed_out[p] <= s;
      repeat (4) @(posedge clock_in);
   endtask
endmodule // pch_link_model

// [test/tb.sv]
// self-checking bench of the port configuration handler
`timescale 1ns/1ps
`include "pch_regs.vh"
module tb;
   logic clock_in = 1'b0;
   logic rst_b_in = 1'b0;
   logic hsel_in = 1'b0;
   logic [31:0] haddr_in = 32'h0;
   logic [1:0] htrans_in = 2'h0;
   logic hwrite_in = 1'b0;
   logic [2:0] hsize_in = 3'h0;
   logic [31:0] hwdata_in = 32'h0;
   logic [31:0] rd, e_rp, at_rp;
   logic [15:0] e_tag, e_q, at_tag;
   wire [31:0] hrdata_out;
   wire hready, hresp, mirror;
   wire [1:0] rec_ev, up, slow, oper, uce, fast_r, slow_r, single, ext, bgn;
   wire [3:0] mode;
   wire [33:0] wbuf;
   wire [15:0] quota;
   int num_errors = 0, comparisons = 0, cycles = 0, n_bgn = 0, e_bgn = 0;
   int e_rc, m_cfg = 0, m_mir = 0;
   int m_mode[2] = '{3, 3}, m_oper[2] = '{0, 0}, m_uce[2] = '{0, 0};
   int m_f[2] = '{1, 1}, m_s[2] = '{1, 1}, m_win[2] = '{0, 0};
   int cv[7] = '{1, 0, 0, 0, 0, 0, 0}, cm[7] = '{1, 1, 2, 3, 2, 0, 2};
   int cr[7] = '{1, 1, 0, 0, 0, 1, 1};
   pch_port_cfg u_dut (.clock_in(clock_in), .rst_b_in(rst_b_in),
      .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
      .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hwdata_in(hwdata_in),
      .hready_in(hready), .hrdata_out(hrdata_out), .hreadyout_out(hready),
      .hresp_out(hresp), .link_recovery_event_in(rec_ev),
      .link_up_in(up), .slow_speed_in(slow), .port_mode_out(mode),
      .port_operational_out(oper), .user_char_enable_out(uce),
      .allow_fast_rate_out(fast_r), .allow_slow_rate_out(slow_r),
      .single_speed_out(single), .extended_window_out(ext),
      .window_buffers_out(wbuf), .quota_out(quota),
      .begin_comm_out(bgn), .mirror_flag_out(mirror));
   pch_link_model u_link (.clock_in(clock_in),
      .link_recovery_event_out(rec_ev), .link_up_out(up),
      .slow_speed_out(slow));
   // ==================================================================
   // clock, hang guard and link start counter
   always #5 clock_in = ~clock_in;
   always @(posedge clock_in) begin
      cycles++;
      if (bgn[1] === 1'b1) n_bgn++;
      if (cycles == 30000) begin
         num_errors++;
         $display("[FAIL] %0t run hung", $time);
         complete_run;
      end
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [33:0] s, e, input string m);
      comparisons++;
      if (s !== e) begin
         num_errors++;
         $display("[FAIL] %0t %s seen %h want %h", $time, m, s, e);
      end
   endtask
   // single word transfer; waits on hready in both phases
   task automatic bus(input logic w, input logic [7:0] a, input int d);
      hsel_in <= 1'b1;
      htrans_in <= 2'h2;
      hwrite_in <= w;
      hsize_in <= 3'h2;
      haddr_in <= {24'h0, a};
      @(posedge clock_in);
      while (hready !== 1'b1) @(posedge clock_in);
      hsel_in <= 1'b0;
      htrans_in <= 2'h0;
      hwdata_in <= d;
      @(posedge clock_in);
      while (hready !== 1'b1) @(posedge clock_in);
      rd = hrdata_out;
   endtask
   // ==================================================================
   // request issue with the expected outcome folded into the model
   task automatic send(input int p, v, md, u, rf, sp, w, bq, mq);
      logic ok;
      logic [31:0] r;
      r = $urandom;
      e_tag = {15'($urandom), 1'(p)};
      e_rp = $urandom;
      ok = mq >= bq && !(md == 1 && v == p) && !(md == 2 && m_mode[p] == 1);
      e_rc = ok ? 0 : 255;
      bus(1, `PCH_REQ0, {8'h02, 8'(p), e_tag});
      bus(1, `PCH_REQ1, e_rp);
      bus(1, `PCH_REQ2, {r[31:24], 8'(bq), 8'(mq), 1'(u), 1'(rf), 2'(md),
         r[3:0]});
      bus(1, `PCH_REQ3, {r[7:0], 8'h03, r[15:8], r[29:24], 2'(sp)});
      bus(1, `PCH_REQ4, {16'(w), r[15:0]});
      bus(1, `PCH_CTRL, {8'h0, 8'(v), 16'h1});
      if (ok) begin
         e_q = {8'(bq), 8'(mq)};
         m_uce[p] = u;
         m_win[p] = w;
         if (sp != 0) m_f[p] = sp / 2;
         if (sp != 0) m_s[p] = sp % 2;
         if (md == 1) m_oper[p] = 0;
         if (md == 3 && m_mode[p] == 1) e_bgn++;
         if (md != 0) m_mode[p] = md;
         if (m_cfg == 0 && rf == 1) m_mir = 1;
         if (m_cfg == 0 && rf == 0 && m_oper[0] + m_oper[1] == 2) m_mir = 0;
      end
   endtask
   task automatic state;
      for (int p = 0; p < 2; p++) begin
         bus(0, 8'h30 + 8'(4 * p), 0);
         chk(34'(rd[5:0]), 34'({1'(m_f[p]), 1'(m_s[p]), 1'(m_uce[p]),
            1'(m_oper[p]), 2'(m_mode[p])}), "port");
         chk(34'({hresp, oper[p], uce[p], fast_r[p], slow_r[p], single[p],
            ext[p]}), 34'({1'b0, 1'(m_oper[p]), 1'(m_uce[p]), 1'(m_f[p]),
            1'(m_s[p]), 1'(m_f[p] ^ m_s[p]), 1'(m_win[p] > 1)}),
            "pins");
      end
      chk(34'(mode), 34'({2'(m_mode[1]), 2'(m_mode[0])}), "mode");
      chk(wbuf, {17'(m_win[1] + 1), 17'(m_win[0] + 1)}, "window");
      chk(34'(mirror), 34'(m_mir), "mirror");
      chk(34'(n_bgn), 34'(e_bgn), "link start");
   endtask
   task automatic fin;
      bus(0, `PCH_STAT, 0);
      while (rd[1:0] !== 2'h1) bus(0, `PCH_STAT, 0);
      chk(34'(rd[31:8]), 34'({e_tag, 8'(e_rc)}), "response");
      bus(0, `PCH_RADDR, 0);
      chk(34'(rd), 34'(e_rp), "resp address");
      if (e_rc == 0) chk(34'(quota), 34'(e_q), "quota");
      bus(1, `PCH_CTRL, 32'h8);
      state;
   endtask
   task automatic alert(input logic [25:0] e);
      bus(0, `PCH_ALERT, 0);
      chk(34'({rd[31:8], rd[1:0]}), 34'(e), "alert");
   endtask
   // ==================================================================
   // main sequence
   initial begin
      void'($urandom(92));
      repeat (10) @(posedge clock_in);
      rst_b_in <= 1'b1;
      @(posedge clock_in);
      state;
      bus(0, `PCH_CFG, 0);
      chk(34'(rd[2:0]), 34'h4, "cfg reset");
      bus(0, 8'h3C, 0);
      chk(34'(rd), 34'h0, "unmapped");
      u_link.come_up(0);
      u_link.come_up(1);
      m_oper = '{1, 1};
      // mode walk of port 1, speed codes 0, 1 and 3 applied (code 2 only in rejected requests), window edge
      for (int i = 0; i < 7; i++) begin
         send(1, cv[i], cm[i], i % 2, cr[i], i % 4, i == 3 ? 16'hFFFF : i,
            7 - i, i == 6 ? 0 : 9 + $urandom % 50);
         fin;
         if (i == 3) u_link.come_up(1);
         if (i == 3) m_oper[1] = 1;
      end
      $display("mode walk done");
      // reflect bit ignored on a single port node
      bus(1, `PCH_CFG, 32'h5);
      m_cfg = 1;
      send(1, 0, 2, 0, 0, 3, 1, 4, 4);
      fin;
      bus(1, `PCH_CFG, 32'h4);
      m_cfg = 0;
      $display("node kind done");
      // alarm threshold of port 0, once only, then rearmed
      send(0, 1, 2, 1, 1, 3, 2, 1, 2);
      fin;
      at_tag = e_tag;
      at_rp = e_rp;
      repeat (3) u_link.recover(0);
      alert({24'h001A00, 2'h1});
      bus(0, `PCH_ATAG, 0);
      chk(34'(rd[15:0]), 34'(at_tag), "alert tag");
      bus(0, `PCH_AADDR, 0);
      chk(34'(rd), 34'(at_rp), "alert address");
      bus(1, `PCH_CTRL, 32'h4);
      u_link.recover(0);
      alert(26'h0);
      bus(0, `PCH_PORT0, 0);
      chk(34'(rd[15:8]), 34'h4, "count");
      bus(1, `PCH_CTRL, 32'h2);
      bus(0, `PCH_PORT0, 0);
      chk(34'(rd[15:8]), 34'h0, "count cleared");
      repeat (3) u_link.recover(0);
      send(0, 1, 0, 1, 1, 0, 2, 1, 2);
      bus(0, `PCH_STAT, 0);
      chk(34'(rd[1:0]), 34'h2, "held response");
      alert({24'h001A00, 2'h1});
      bus(1, `PCH_CTRL, 32'h4);
      fin;
      $display("alarm done");
      // slow link on a dual rate port
      u_link.set_slow(1, 1'b1);
      send(1, 0, 2, 0, 1, 3, 0, 5, 5);
      fin;
      alert({24'h000605, 2'h3});
      bus(1, `PCH_CTRL, 32'h4);
      u_link.set_slow(1, 1'b0);
      alert(26'h0);
      $display("speed alert done");
      complete_run;
   end
endmodule // tb
